//--- aaf_pkg.sv
// package: constants for the accumulator add and flags datapath slice
package aaf_pkg;
   // register indices on the plain register port
   localparam logic [3:0] ADDR_FIRST_ACC   = 4'h0;
   localparam logic [3:0] ADDR_SECOND_ACC  = 4'h1;
   localparam logic [3:0] ADDR_FLAGS       = 4'h2;
   localparam logic [3:0] ADDR_INDEX_X_LO  = 4'h3;
   localparam logic [3:0] ADDR_INDEX_X_HI  = 4'h4;
   localparam logic [3:0] ADDR_INDEX_Y_LO  = 4'h5;
   localparam logic [3:0] ADDR_INDEX_Y_HI  = 4'h6;
   localparam logic [3:0] ADDR_STATUS      = 4'h7;
   // flag bit positions
   localparam int FLAG_STOP_DIS = 7;
   localparam int FLAG_XMASK    = 6;
   localparam int FLAG_HALF     = 5;
   localparam int FLAG_IMASK    = 4;
   localparam int FLAG_NEG      = 3;
   localparam int FLAG_ZERO     = 2;
   localparam int FLAG_OVF      = 1;
   localparam int FLAG_CARRY    = 0;
   // reset values
   localparam logic [7:0] FLAGS_RESET = 8'hD0;
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [15:0] PC_RESET   = 16'h0000;
   // opcode of the accumulator add
   localparam logic [7:0] OPC_ADD_SECOND_TO_FIRST = 8'h1B;
   // addressing mode selector for the operand address unit
   localparam logic [1:0] AMODE_DIRECT  = 2'h0;
   localparam logic [1:0] AMODE_INDEX_X = 2'h1;
   localparam logic [1:0] AMODE_INDEX_Y = 2'h2;
   localparam logic [1:0] AMODE_BRANCH  = 2'h3;
   typedef enum logic [1:0] {AAF_FETCH, AAF_EXEC} aaf_state_e;
endpackage : aaf_pkg

//--- aaf_core.sv
// module: accumulator add datapath with condition flags and operand address unit
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
// ====================================================================
// What this block does
// (RL1) paired accumulator is first accumulator high byte, second accumulator low byte
// (RL2) flags bit 7 stop-disable, 6 nmi mask, 5 half carry, 4 irq mask
// (RL3) flags bit 3 negative, 2 zero, 1 overflow, 0 carry
// (RL4) direct address is operand byte with upper byte forced to zero
// (RL5) indexed address is index plus unsigned offset 0..255
// (RL6) branch target is next address plus sign-extended offset -128..127
// (RL7) add writes 8-bit sum into first accumulator, second unchanged
// (RL8) half carry set on carry out of bit 3
// (RL9) negative takes result bit 7
// (RL10) zero set exactly when result is all zero
// (RL11) overflow set when operand signs equal and result sign differs
// (RL12) carry set on carry out of bit 7 from sign bits
// (RL13) opcode 1B, two cycles: opcode fetch then next address read
// (RL14) add leaves stop-disable and both mask bits unchanged
// (RL15) all flags commit in the same cycle as the sum write
module aaf_core
   import aaf_pkg::*;
(
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   input  wire logic        clk_en_i,
   // register port
   input  wire logic [3:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [7:0]  reg_rdata_o,
   // instruction fetch on the cpu bus
   output logic      [15:0] fetch_addr_o,
   output logic             fetch_rd_o,
   input  wire logic [7:0]  fetch_data_i,
   input  wire logic        run_i,
   // operand address unit
   input  wire logic [1:0]  amode_i,
   input  wire logic [7:0]  offset_i,
   input  wire logic [15:0] next_addr_i,
   output logic      [15:0] oper_addr_o,
   // state views
   output logic      [15:0] paired_accumulator_o,
   output logic      [7:0]  condition_flags_o,
   output logic             add_done_o
);
   import aaf_pkg::*;

   // ====================================================================
   // state
   typedef struct packed {
      aaf_state_e  st;
      logic [7:0]  first_acc;
      logic [7:0]  second_acc;
      logic [7:0]  flags;
      logic [15:0] idx_x;
      logic [15:0] idx_y;
      logic [15:0] pc;
      logic [7:0]  rdata;
      logic [15:0] oper_addr;
      logic        done;
      logic [7:0]  add_count;
   } aaf_state_s;

   aaf_state_s s_r;
   aaf_state_s s_nxt;

   // ====================================================================
   // functions
   function automatic logic [15:0] aaf_add16(input logic [15:0] base, input logic [15:0] ofs);
      aaf_add16 = base + ofs;
   endfunction

   // carry out of one bit from operand and result bits; serves bit 3 and bit 7 alike
   function automatic logic aaf_carry_out(input logic x, input logic m, input logic r);
      aaf_carry_out = (x & m) | (m & ~r) | (~r & x);
   endfunction

   function automatic logic [15:0] aaf_oper_addr(input logic [1:0]  mode,
                                                 input logic [7:0]  ofs,
                                                 input logic [15:0] x,
                                                 input logic [15:0] y,
                                                 input logic [15:0] nxt);
      logic [15:0] a;
      a = 16'h0000;
      unique case (mode)
         AMODE_DIRECT:  a = {8'h00, ofs};                           // [RL4]
         AMODE_INDEX_X: a = aaf_add16(x, {8'h00, ofs});             // [RL5]
         AMODE_INDEX_Y: a = aaf_add16(y, {8'h00, ofs});             // [RL5]
         AMODE_BRANCH:  a = aaf_add16(nxt, {{8{ofs[7]}}, ofs});     // [RL6]
      endcase
      return a;
   endfunction

   // ====================================================================
   // next state
   logic [7:0] sum;
   logic       c3;
   logic       a7;
   logic       b7;
   logic       r7;

   always_comb begin
      s_nxt = s_r;
      sum   = s_r.first_acc + s_r.second_acc;
      c3    = aaf_carry_out(s_r.first_acc[3], s_r.second_acc[3], sum[3]);
      a7    = s_r.first_acc[7];
      b7    = s_r.second_acc[7];
      r7    = sum[7];
      s_nxt.done      = 1'b0;
      s_nxt.oper_addr = aaf_oper_addr(amode_i, offset_i, s_r.idx_x, s_r.idx_y, next_addr_i);
      s_nxt.rdata     = 8'h00;

      // one fetch per cycle; an opcode other than the add is not executed here
      unique case (s_r.st)
         AAF_FETCH: begin
            if (run_i) begin
               s_nxt.pc = s_r.pc + 16'h0001;
               if (fetch_data_i == OPC_ADD_SECOND_TO_FIRST) begin       // [RL13]
                  s_nxt.st = AAF_EXEC;
               end
            end
         end
         AAF_EXEC: begin
            // second cycle reads the next address; its data are discarded [RL13]
            s_nxt.st        = AAF_FETCH;
            s_nxt.first_acc = sum;                                       // [RL7]
            // flags commit together with the sum [RL15]
            s_nxt.flags[FLAG_HALF]  = c3;                                // [RL8]
            s_nxt.flags[FLAG_NEG]   = r7;                                // [RL9]
            s_nxt.flags[FLAG_ZERO]  = (sum == 8'h00);                    // [RL10]
            s_nxt.flags[FLAG_OVF]   = (a7 & b7 & ~r7) | (~a7 & ~b7 & r7); // [RL11]
            s_nxt.flags[FLAG_CARRY] = aaf_carry_out(a7, b7, r7);         // [RL12]
            // stop-disable and mask bits keep their value [RL14]
            s_nxt.done      = 1'b1;
            s_nxt.add_count = s_r.add_count + 8'h01;
         end
      endcase

      // software writes; an add commit in the same cycle wins on the first accumulator and the flags
      if (reg_wr_i && !(s_r.st == AAF_EXEC && (reg_addr_i == ADDR_FIRST_ACC
                                               || reg_addr_i == ADDR_FLAGS))) begin
         unique case (reg_addr_i)
            ADDR_FIRST_ACC:  s_nxt.first_acc   = reg_wdata_i;
            ADDR_SECOND_ACC: s_nxt.second_acc  = reg_wdata_i;
            ADDR_FLAGS:      s_nxt.flags       = reg_wdata_i;            // [RL2] [RL3]
            ADDR_INDEX_X_LO: s_nxt.idx_x[7:0]  = reg_wdata_i;
            ADDR_INDEX_X_HI: s_nxt.idx_x[15:8] = reg_wdata_i;
            ADDR_INDEX_Y_LO: s_nxt.idx_y[7:0]  = reg_wdata_i;
            ADDR_INDEX_Y_HI: s_nxt.idx_y[15:8] = reg_wdata_i;
            default: ;
         endcase
      end

      if (reg_rd_i) begin
         unique case (reg_addr_i)
            ADDR_FIRST_ACC:  s_nxt.rdata = s_r.first_acc;
            ADDR_SECOND_ACC: s_nxt.rdata = s_r.second_acc;
            ADDR_FLAGS:      s_nxt.rdata = s_r.flags;
            ADDR_INDEX_X_LO: s_nxt.rdata = s_r.idx_x[7:0];
            ADDR_INDEX_X_HI: s_nxt.rdata = s_r.idx_x[15:8];
            ADDR_INDEX_Y_LO: s_nxt.rdata = s_r.idx_y[7:0];
            ADDR_INDEX_Y_HI: s_nxt.rdata = s_r.idx_y[15:8];
            ADDR_STATUS:     s_nxt.rdata = s_r.add_count;
            default:         s_nxt.rdata = 8'h00;
         endcase
      end
   end

   // ====================================================================
   // registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         s_r.st         <= AAF_FETCH;
         s_r.first_acc  <= ACC_RESET;
         s_r.second_acc <= ACC_RESET;
         s_r.flags      <= FLAGS_RESET;
         s_r.idx_x      <= 16'h0000;
         s_r.idx_y      <= 16'h0000;
         s_r.pc         <= PC_RESET;
         s_r.rdata      <= 8'h00;
         s_r.oper_addr  <= 16'h0000;
         s_r.done       <= 1'b0;
         s_r.add_count  <= 8'h00;
      end else if (clk_en_i) begin
         s_r <= s_nxt;
      end
   end

   // ====================================================================
   // outputs
   assign reg_rdata_o          = s_r.rdata;
   assign fetch_addr_o         = s_r.pc;
   assign fetch_rd_o           = run_i | (s_r.st == AAF_EXEC);
   assign oper_addr_o          = s_r.oper_addr;
   assign paired_accumulator_o = {s_r.first_acc, s_r.second_acc};   // [RL1]
   assign condition_flags_o    = s_r.flags;
   assign add_done_o           = s_r.done;

endmodule : aaf_core

//--- aaf_monitor.sv
// checker: port-level properties of the accumulator add datapath
`timescale 1ns/1ps
module aaf_monitor
   import aaf_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        srst_i,
   input wire logic        run_i,
   input wire logic [1:0]  amode_i,
   input wire logic [7:0]  offset_i,
   input wire logic [15:0] next_addr_i,
   input wire logic        fetch_rd_o,
   input wire logic [15:0] fetch_addr_o,
   input wire logic [15:0] oper_addr_o,
   input wire logic [15:0] paired_accumulator_o,
   input wire logic [7:0]  condition_flags_o,
   input wire logic        add_done_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);
   wire logic [7:0] acc_a = paired_accumulator_o[15:8];
   wire logic [7:0] acc_b = paired_accumulator_o[7:0];
   wire logic [7:0] fl    = condition_flags_o;
   done_single_a: assert property (add_done_o |=> !add_done_o)
      else $error("done pulse longer than one cycle");
   sum_commit_a: assert property (add_done_o |-> acc_a == $past(acc_a) + $past(acc_b))
      else $error("sum not written to first accumulator");
   second_kept_a: assert property (add_done_o |-> $stable(acc_b))
      else $error("second accumulator changed by add");
   half_flag_a: assert property (add_done_o |->
      fl[5] == (({1'b0, $past(acc_a[3:0])} + $past(acc_b[3:0])) > 5'h0F))
      else $error("half carry wrong");
   neg_flag_a: assert property (add_done_o |-> fl[3] == acc_a[7])
      else $error("negative flag wrong");
   zero_flag_a: assert property (add_done_o |-> fl[2] == (acc_a == 8'h00))
      else $error("zero flag wrong");
   ovf_flag_a: assert property (add_done_o |->
      fl[1] == ($past(acc_a[7]) == $past(acc_b[7]) && acc_a[7] != $past(acc_a[7])))
      else $error("overflow flag wrong");
   carry_flag_a: assert property (add_done_o |->
      fl[0] == (({1'b0, $past(acc_a)} + $past(acc_b)) > 9'h0FF))
      else $error("carry flag wrong");
   mask_keep_a: assert property (add_done_o |-> $stable(fl[7:6]) && $stable(fl[4]))
      else $error("mask bits changed by add");
   direct_addr_a: assert property ($past(amode_i) == AMODE_DIRECT && !$past(srst_i) |->
      oper_addr_o == {8'h00, $past(offset_i)})
      else $error("direct address wrong");
   branch_addr_a: assert property ($past(amode_i) == AMODE_BRANCH && !$past(srst_i) |->
      oper_addr_o == $past(next_addr_i) + {{8{$past(offset_i[7])}}, $past(offset_i)})
      else $error("branch target wrong");
   fetch_rd_a: assert property (add_done_o |->
      $past(run_i, 2) && $past(fetch_rd_o) && $past(fetch_rd_o, 2))
      else $error("add did not take two read cycles");
   next_read_a: assert property (add_done_o |->
      $past(fetch_addr_o) == $past(fetch_addr_o, 2) + 16'h0001)
      else $error("second add cycle not at the next address");
endmodule // aaf_monitor
bind aaf_core aaf_monitor u_mon (.ref_clk_i, .srst_i, .run_i, .amode_i, .offset_i, .next_addr_i,
   .fetch_rd_o, .fetch_addr_o, .oper_addr_o, .paired_accumulator_o, .condition_flags_o,
   .add_done_o);

//--- accumulator_add_and_flags_bench.sv
// testbench: table of adds, flag masks, register reads and operand addresses
`timescale 1ns/1ps
module accumulator_add_and_flags_bench;
   import aaf_pkg::*;
   logic        ref_clk_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, run_i = 1'b0;
   logic        clk_en_i = 1'b1;
   logic [3:0]  reg_addr_i = 4'h0;
   logic [7:0]  reg_wdata_i = 8'h00, fetch_data_i = 8'h00, offset_i = 8'h00, reg_rdata_o;
   logic [1:0]  amode_i = 2'h0;
   logic [15:0] next_addr_i = 16'h0000, fetch_addr_o, oper_addr_o, paired_accumulator_o;
   logic [7:0]  condition_flags_o;
   logic        fetch_rd_o, add_done_o;
   int          miscompares = 0, checks = 0;
   // a, b, sum, flags expected with masks at their reset value
   logic [31:0] rows [5] = '{32'h0808_10F0, 32'h8080_00D7, 32'h7F01_80FA, 32'hFF01_00F5,
                             32'h1234_46D0};
   // mode, offset, next address, expected operand address (index x 1234, index y 5600)
   logic [41:0] am [5] = '{{2'h0, 8'h80, 16'h0, 16'h0080}, {2'h1, 8'hFF, 16'h0, 16'h1333},
                           {2'h2, 8'h10, 16'h0, 16'h5610},
                           {2'h3, 8'h80, 16'h2000, 16'h1F80}, {2'h3, 8'h7F, 16'h2000, 16'h207F}};
   aaf_core DUT (.ref_clk_i, .srst_i, .clk_en_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .fetch_addr_o, .fetch_rd_o, .fetch_data_i, .run_i, .amode_i,
      .offset_i, .next_addr_i, .oper_addr_o, .paired_accumulator_o, .condition_flags_o,
      .add_done_o);
   always #5 ref_clk_i = ~ref_clk_i;
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata_o});
   endtask
   // done is awaited with a small bound; a lost add shows up as a miss
   task automatic add;
      @(posedge ref_clk_i);
      run_i <= 1'b1;
      fetch_data_i <= OPC_ADD_SECOND_TO_FIRST;
      @(posedge ref_clk_i);
      run_i <= 1'b0;
      fetch_data_i <= 8'h00;
      repeat (4) begin
         @(posedge ref_clk_i);
         #1;
         if (add_done_o === 1'b1) break;
      end
      chk("done", 16'h1, {15'h0, add_done_o});
   endtask
   initial begin
      repeat (4) @(posedge ref_clk_i);
      srst_i <= 1'b0;
      rd(ADDR_FLAGS, FLAGS_RESET);
      chk("paired", 16'h0000, paired_accumulator_o);
      chk("pc", 16'h0000, fetch_addr_o);
      foreach (rows[i]) begin
         wr(ADDR_FIRST_ACC, rows[i][31:24]);
         wr(ADDR_SECOND_ACC, rows[i][23:16]);
         add();
         chk("paired", {rows[i][15:8], rows[i][23:16]}, paired_accumulator_o);
         chk("flags", {8'h00, rows[i][7:0]}, {8'h00, condition_flags_o});
      end
      chk("pc", 16'h0005, fetch_addr_o);
      // masks cleared by software must survive an add
      wr(ADDR_FLAGS, 8'h00);
      wr(ADDR_FIRST_ACC, 8'h7F);
      add();
      rd(ADDR_FLAGS, 8'h2A);
      rd(ADDR_FIRST_ACC, 8'hB3);
      // an opcode other than the add only moves the program counter
      @(posedge ref_clk_i);
      run_i <= 1'b1;
      @(posedge ref_clk_i);
      run_i <= 1'b0;
      @(posedge ref_clk_i);
      #1 chk("pc", 16'h0007, fetch_addr_o);
      chk("paired", 16'hB334, paired_accumulator_o);
      rd(ADDR_STATUS, 8'h06);
      // with the clock enable low a write must not land
      @(posedge ref_clk_i);
      clk_en_i <= 1'b0;
      wr(ADDR_FIRST_ACC, 8'h55);
      clk_en_i <= 1'b1;
      #1 chk("frozen", 16'hB334, paired_accumulator_o);
      rd(4'hF, 8'h00);
      wr(ADDR_INDEX_X_LO, 8'h34);
      wr(ADDR_INDEX_X_HI, 8'h12);
      wr(ADDR_INDEX_Y_LO, 8'h00);
      wr(ADDR_INDEX_Y_HI, 8'h56);
      foreach (am[i]) begin
         @(posedge ref_clk_i);
         {amode_i, offset_i, next_addr_i} <= am[i][41:16];
         @(posedge ref_clk_i);
         #1 chk("oper", am[i][15:0], oper_addr_o);
      end
      give_verdict();
   end
   initial begin
      #20000;
      miscompares++;
      give_verdict();
   end
endmodule // accumulator_add_and_flags_bench
